// [logic/pmudcp_dev.sv]
// device end: static handover, interface select and spi slave
`timescale 1ns/100ps
`include "pmudcp_regs.svh"
module pmudcp_dev
   import pmudcp_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // link
   pmudcp_if.dev            lnk,
   // mode and start-up
   input  wire logic        dynamic_mode,
   input  wire logic        button_event,
   input  wire logic        startup_done,
   input  wire logic [3:0]  seq_enables,
   // supply enables and pull-ups
   output logic      [3:0]  supply_en,
   output logic             ready_pullup_en,
   output logic             select_pullup_en,
   output logic             spi_selected,
   // register access
   output logic             reg_wr,
   output logic             reg_rd,
   output logic      [6:0]  reg_addr,
   output logic      [7:0]  reg_wdata,
   input  wire logic [7:0]  reg_rdata
);
   // *********************************
   // pin synchronisers
   // *********************************
   logic [3:0] pins_s;
   pmudcp_sync #(.W(4)) u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .clk_en  (clk_en),
      .d       ({lnk.ready_irq_pin, lnk.ctrl_pin_four,
                 lnk.ctrl_pin_three, lnk.ctrl_pin_one}),
      .q       (pins_s)
   );
   wire sck_s   = pins_s[0];
   wire sdi_s   = pins_s[1];
   wire sel_s   = pins_s[2];
   wire ready_s = pins_s[3];

   // *********************************
   // control state machine
   // *********************************
   localparam logic [8:0] SETTLE = 9'(`PMUDCP_SETTLE_CYC);
   pmudcp_state_e state_r;
   logic          ready_lat_r;
   logic          pins_own_r;
   logic [8:0]    wait_r;
   logic          sck_d_r;
   logic          power_good_r;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_r          <= PMUDCP_ST_STARTUP;
         ready_lat_r      <= 1'b1;
         pins_own_r       <= 1'b0;
         wait_r           <= '0;
         power_good_r     <= 1'b0;
         select_pullup_en <= 1'b0;
         spi_selected     <= 1'b0;
      end else if (clk_en) begin
         case (state_r)
            PMUDCP_ST_STARTUP: begin
               if (dynamic_mode && button_event) begin
                  select_pullup_en <= 1'b1;
                  wait_r           <= SETTLE;
                  state_r          <= PMUDCP_ST_SELWAIT;
               end else if (!dynamic_mode && startup_done) begin
                  state_r <= PMUDCP_ST_LATCH;
               end
            end
            PMUDCP_ST_LATCH: begin
               ready_lat_r  <= ready_s;
               power_good_r <= 1'b1;
               state_r      <= PMUDCP_ST_WATCH;
            end
            PMUDCP_ST_WATCH: begin
               if (ready_s != ready_lat_r) begin
                  pins_own_r <= 1'b1;
                  state_r    <= PMUDCP_ST_PINS;
               end
            end
            PMUDCP_ST_PINS: begin
               pins_own_r <= 1'b1;
            end
            PMUDCP_ST_SELWAIT: begin
               if (wait_r != 9'h000) begin
                  wait_r <= wait_r - 9'h001;
               end else begin
                  spi_selected     <= sel_s;
                  select_pullup_en <= 1'b0;
                  power_good_r     <= startup_done;
                  state_r          <= PMUDCP_ST_SELDONE;
               end
            end
            PMUDCP_ST_SELDONE: begin
               power_good_r <= startup_done;
            end
            default: state_r <= PMUDCP_ST_STARTUP;
         endcase
      end
   end
   assign lnk.power_good  = power_good_r;
   // pull-up on ready stays until handover in static mode
   assign ready_pullup_en = !dynamic_mode && !pins_own_r;

   // *********************************
   // supply enables
   // *********************************
   logic two_m_r;
   logic lnk_two_s;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         supply_en <= `PMUDCP_EN_RST;
      end else if (clk_en) begin
         if (!dynamic_mode && pins_own_r) begin
            // boost, buck, linear a, linear b
            supply_en <= {sel_s, sdi_s, lnk_two_s, sck_s};
         end else begin
            supply_en <= {1'b0, seq_enables[2:0]};
         end
      end
   end
   // pin two is an input only in static mode; sample it too
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         two_m_r   <= 1'b0;
         lnk_two_s <= 1'b0;
      end else if (clk_en) begin
         two_m_r   <= lnk.ctrl_pin_two_i;
         lnk_two_s <= two_m_r;
      end
   end

   // *********************************
   // spi slave on sampled serial clock
   // *********************************
   // the serial clock is sampled by the fast sys_clk, never the
   // slow register clock, so the host's bit rate of sys_clk/32 is safe
   wire spi_on = dynamic_mode && spi_selected && !sel_s;
   wire rise   = spi_on && sck_s && !sck_d_r;
   wire fall   = spi_on && !sck_s && sck_d_r;
   logic [2:0] bit_r;
   logic       phase_r;
   logic       rd_r;
   logic [7:0] sh_r;
   logic       drive_r;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sck_d_r <= 1'b1;
         bit_r   <= 3'h0;
         phase_r <= 1'b0;
         rd_r    <= 1'b0;
         sh_r    <= 8'h00;
         drive_r <= 1'b0;
         reg_wr  <= 1'b0;
         reg_rd  <= 1'b0;
         reg_addr  <= 7'h00;
         reg_wdata <= 8'h00;
      end else if (clk_en) begin
         sck_d_r <= sck_s;
         reg_wr  <= 1'b0;
         reg_rd  <= 1'b0;
         if (!spi_on) begin
            bit_r   <= 3'h0;
            phase_r <= 1'b0;
            drive_r <= 1'b0;
         end else if (rise) begin
            bit_r <= bit_r + 3'h1;
            if (!(phase_r && rd_r)) begin
               sh_r <= {sh_r[6:0], sdi_s};
            end
            if (bit_r == 3'h7) begin
               phase_r <= !phase_r;
               if (!phase_r) begin
                  rd_r     <= sh_r[6];
                  reg_addr <= {sh_r[5:0], sdi_s};
                  reg_rd   <= sh_r[6];
               end else if (!rd_r) begin
                  reg_wdata <= {sh_r[6:0], sdi_s};
                  reg_wr    <= 1'b1;
               end
            end
         end else if (fall) begin
            if (phase_r && rd_r && bit_r == 3'h0 && !drive_r) begin
               // msb already loaded; only start driving it
               drive_r <= 1'b1;
            end else if (drive_r && bit_r == 3'h0) begin
               drive_r <= 1'b0;
            end else if (drive_r) begin
               sh_r <= {sh_r[6:0], 1'b0};
            end
         end
         if (reg_rd) begin
            sh_r <= reg_rdata;
         end
      end
   end
   // first bit drives as soon as data byte starts after read command
   assign lnk.ctrl_pin_two_o  = sh_r[7];
   assign lnk.ctrl_pin_two_oe = drive_r || (spi_on && phase_r && rd_r
                                && bit_r == 3'h0 && !sck_d_r);
endmodule

// [logic/pmudcp_regs.svh]
// constants for the power unit digital control port
`ifndef PMUDCP_REGS_SVH
`define PMUDCP_REGS_SVH
// select pull-up settle time in ns and in sys_clk cycles (4 ns)
`define PMUDCP_SETTLE_NS       1000
`define PMUDCP_CLK_NS          4
`define PMUDCP_SETTLE_CYC      (`PMUDCP_SETTLE_NS / `PMUDCP_CLK_NS)
// command byte fields
`define PMUDCP_CMD_RD_BIT      7
`define PMUDCP_ADDR_W          7
// host serial clock divider half period in sys_clk cycles
`define PMUDCP_HOST_HALF       16
// host gap between byte transfers in sys_clk cycles
`define PMUDCP_HOST_GAP        64
// reset value of supply enables
`define PMUDCP_EN_RST          4'h0
`endif

// [logic/pmudcp_pkg.sv]
// types shared by both ends of the control port
package pmudcp_pkg;
   typedef enum logic [2:0] {
      PMUDCP_ST_STARTUP = 3'b000,
      PMUDCP_ST_LATCH   = 3'b001,
      PMUDCP_ST_WATCH   = 3'b010,
      PMUDCP_ST_PINS    = 3'b011,
      PMUDCP_ST_SELWAIT = 3'b100,
      PMUDCP_ST_SELDONE = 3'b101
   } pmudcp_state_e;
   typedef enum logic [1:0] {
      PMUDCP_H_IDLE = 2'b00,
      PMUDCP_H_SHIFT = 2'b01,
      PMUDCP_H_GAP  = 2'b10
   } pmudcp_host_e;
endpackage

// [logic/pmudcp_if.sv]
// pin-level carrier between the power unit port and its host
`timescale 1ns/100ps
interface pmudcp_if;
   logic ctrl_pin_one;
   logic ctrl_pin_two_i;
   logic ctrl_pin_two_o;
   logic ctrl_pin_two_oe;
   logic ctrl_pin_three;
   logic ctrl_pin_four;
   logic ready_irq_pin;
   logic power_good;
   modport dev (
      input  ctrl_pin_one, ctrl_pin_two_i, ctrl_pin_three, ctrl_pin_four,
             ready_irq_pin,
      output ctrl_pin_two_o, ctrl_pin_two_oe, power_good
   );
   modport host (
      output ctrl_pin_one, ctrl_pin_two_i, ctrl_pin_three, ctrl_pin_four,
             ready_irq_pin,
      input  ctrl_pin_two_o, ctrl_pin_two_oe, power_good
   );
endinterface

// [logic/pmudcp_sync.sv]
// two-flop synchroniser for a bundle of levels
`timescale 1ns/100ps
module pmudcp_sync #(
   parameter int W = 1
) (
   // clock
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic         clk_en,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta_r <= '0;
         q      <= '0;
      end else if (clk_en) begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// [logic/pmudcp_host.sv]
// host end: drives control pins, ready and a serial master
`timescale 1ns/100ps
`include "pmudcp_regs.svh"
module pmudcp_host
   import pmudcp_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       clk_en,
   // link
   pmudcp_if.host          lnk,
   // static control
   input  wire logic [3:0] pin_levels,
   input  wire logic       take_control,
   // serial request
   input  wire logic       req,
   input  wire logic [7:0] cmd,
   input  wire logic [7:0] wdata,
   output logic            busy,
   output logic            done,
   output logic      [7:0] rdata,
   output logic            power_good_s
);
   // *********************************
   // power-good and data in sync
   // *********************************
   logic [1:0] in_s;
   pmudcp_sync #(.W(2)) u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .clk_en  (clk_en),
      .d       ({lnk.power_good,
                 lnk.ctrl_pin_two_oe & lnk.ctrl_pin_two_o}),
      .q       (in_s)
   );
   assign power_good_s = in_s[1];

   // *********************************
   // serial master
   // *********************************
   pmudcp_host_e st_r;
   logic [4:0]  div_r;
   logic [6:0]  gap_r;
   logic [3:0]  cnt_r;
   logic        byte_r;
   logic [15:0] sh_r;
   logic        sck_r;
   logic        cs_n_r;
   logic        ready_r;
   logic [7:0]  rx_r;
   logic        rd_r;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ready_r <= 1'b1;
      end else if (clk_en && take_control) begin
         ready_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r   <= PMUDCP_H_IDLE;
         div_r  <= 5'h00;
         gap_r  <= 7'h00;
         cnt_r  <= 4'h0;
         byte_r <= 1'b0;
         sh_r   <= 16'h0000;
         sck_r  <= 1'b1;
         cs_n_r <= 1'b1;
         done   <= 1'b0;
         rdata  <= 8'h00;
         rx_r   <= 8'h00;
         rd_r   <= 1'b0;
      end else if (clk_en) begin
         done <= 1'b0;
         case (st_r)
            PMUDCP_H_IDLE: begin
               if (req) begin
                  sh_r   <= {cmd, wdata};
                  rd_r   <= cmd[`PMUDCP_CMD_RD_BIT];
                  cs_n_r <= 1'b0;
                  byte_r <= 1'b0;
                  cnt_r  <= 4'h0;
                  div_r  <= 5'h00;
                  st_r   <= PMUDCP_H_SHIFT;
               end
            end
            PMUDCP_H_SHIFT: begin
               if (div_r == 5'(`PMUDCP_HOST_HALF - 1)) begin
                  div_r <= 5'h00;
                  sck_r <= !sck_r;
                  if (!sck_r) begin
                     // rising: both sides capture; data holds still here
                     rx_r <= {rx_r[6:0], in_s[0]};
                     if (cnt_r == 4'h7) begin
                        cnt_r <= 4'h0;
                        gap_r <= 7'h00;
                        st_r  <= PMUDCP_H_GAP;
                     end else begin
                        cnt_r <= cnt_r + 4'h1;
                     end
                  end else if (cnt_r != 4'h0) begin
                     // falling: next bit; the first was set up earlier
                     sh_r <= {sh_r[14:0], 1'b0};
                  end
               end else begin
                  div_r <= div_r + 5'h01;
               end
            end
            PMUDCP_H_GAP: begin
               if (gap_r == 7'(`PMUDCP_HOST_GAP)) begin
                  if (byte_r) begin
                     cs_n_r <= 1'b1;
                     rdata  <= rx_r;
                     done   <= 1'b1;
                     st_r   <= PMUDCP_H_IDLE;
                  end else begin
                     byte_r <= 1'b1;
                     // bring the data byte msb to the front
                     sh_r   <= {sh_r[14:0], 1'b0};
                     div_r  <= 5'h00;
                     st_r   <= PMUDCP_H_SHIFT;
                  end
               end else begin
                  gap_r <= gap_r + 7'h01;
               end
            end
            default: st_r <= PMUDCP_H_IDLE;
         endcase
      end
   end
   assign busy = (st_r != PMUDCP_H_IDLE);

   // *********************************
   // pin drive
   // *********************************
   wire spi_mode = busy;
   // data in held low during read data byte for three-wire use
   wire mosi = (byte_r && rd_r) ? 1'b0 : sh_r[15];
   // static enable for pin two; the device ignores it under spi
   assign lnk.ctrl_pin_two_i = pin_levels[1];
   assign lnk.ctrl_pin_one   = spi_mode ? sck_r : pin_levels[0];
   assign lnk.ctrl_pin_three = spi_mode ? mosi : pin_levels[2];
   assign lnk.ctrl_pin_four  = spi_mode ? cs_n_r : pin_levels[3];
   assign lnk.ready_irq_pin  = ready_r;
endmodule

// [testbench/pmudcp_chk.sv]
// pin-level assertions for the control port link
`timescale 1ns/100ps
module pmudcp_chk (
   // clock and mode
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic dynamic_mode,
   // link pins
   input wire logic ctrl_pin_one,
   input wire logic ctrl_pin_two_o,
   input wire logic ctrl_pin_two_oe,
   input wire logic ctrl_pin_three,
   input wire logic ctrl_pin_four,
   input wire logic ready_irq_pin,
   input wire logic power_good
);
   logic [4:0] rise_cnt_r;
   logic       rd_cmd_r;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // ****************************************
   // frame bookkeeping
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (rst || $fell(ctrl_pin_four)) begin
         rise_cnt_r <= 5'h00;
         rd_cmd_r   <= 1'b0;
      end else if ($rose(ctrl_pin_one) && !ctrl_pin_four) begin
         rise_cnt_r <= rise_cnt_r + 5'h01;
         if (rise_cnt_r == 5'h00) begin
            rd_cmd_r <= ctrl_pin_three;
         end
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   a_sck_idle_high: assert property (
      dynamic_mode && ctrl_pin_four |-> ctrl_pin_one)
      else $error("serial clock low while deselected");
   a_sck_in_frame: assert property (
      !$past(rst) && dynamic_mode && $changed(ctrl_pin_one) |-> !ctrl_pin_four)
      else $error("serial clock moved outside a frame");
   a_out_on_read: assert property (
      $rose(ctrl_pin_two_oe) |-> !ctrl_pin_four && rd_cmd_r)
      else $error("serial out driven outside a read");
   a_out_release_sel: assert property (
      $rose(ctrl_pin_four) |-> ##[0:4] !ctrl_pin_two_oe)
      else $error("serial out held after deselect");
   a_write_out_quiet: assert property (
      !rd_cmd_r && !ctrl_pin_four |-> !ctrl_pin_two_oe)
      else $error("serial out driven during a write");
   a_out_stable_high: assert property (
      ctrl_pin_two_oe && $past(ctrl_pin_two_oe) && ctrl_pin_one
      && $past(ctrl_pin_one) |-> $stable(ctrl_pin_two_o))
      else $error("serial out moved while clock high");
   a_in_stable_rise: assert property (
      dynamic_mode && !ctrl_pin_four && $rose(ctrl_pin_one)
      |-> $stable(ctrl_pin_three) ##1 $stable(ctrl_pin_three))
      else $error("serial in moved at the capture edge");
   a_pg_holds: assert property (
      !$past(rst) && $past(power_good) |-> power_good)
      else $error("power good dropped");
   a_frame_sixteen: assert property (
      $rose(ctrl_pin_four) && rise_cnt_r != 5'h00 |-> rise_cnt_r == 5'h10)
      else $error("frame without two whole bytes");
   a_in_quiet_read: assert property (
      dynamic_mode && !ctrl_pin_four && rd_cmd_r && $rose(ctrl_pin_one)
      && rise_cnt_r >= 5'h08 |-> !ctrl_pin_three)
      else $error("serial in driven during read data");
   a_ready_after_pins: assert property (
      $fell(ready_irq_pin) |-> $stable(ctrl_pin_one)
      && $stable(ctrl_pin_three) && $stable(ctrl_pin_four))
      else $error("control pins moved as ready fell");
endmodule

// [testbench/pmu_digital_control_port_tb_top.sv]
// self-checking bench joining device and host ends of the control port
`timescale 1ns/100ps
module pmu_digital_control_port_tb_top
   import pmudcp_pkg::*;
;
   typedef struct {logic [7:0] cmd; logic [7:0] data;} pmudcp_row_s;
   logic       sys_clk = 1'b0;
   logic       rst = 1'b1;
   logic       dynamic_mode, button_event, startup_done, take_control, req;
   logic [3:0] seq_enables, pin_levels, supply_en;
   logic       ready_pullup_en, select_pullup_en, spi_selected;
   logic       reg_wr, reg_rd, busy, done, power_good_s;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, cmd, wdata, rdata;
   int         n_mismatch = 0;
   int         checks = 0;
   int         n_done = 0;
   int         n_wr = 0;
   int         n_rd = 0;
   int         cyc = 0;
   pmudcp_row_s rows [5] = '{'{8'h00, 8'ha5}, '{8'h7f, 8'h5a},
      '{8'h81, 8'h3c}, '{8'hff, 8'hc3}, '{8'h80, 8'h01}};

   pmudcp_if lnk ();
   pmudcp_dev u_pmudcp_dev (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
      .lnk(lnk.dev), .dynamic_mode(dynamic_mode),
      .button_event(button_event), .startup_done(startup_done),
      .seq_enables(seq_enables), .supply_en(supply_en),
      .ready_pullup_en(ready_pullup_en), .select_pullup_en(select_pullup_en),
      .spi_selected(spi_selected), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   pmudcp_host u_pmudcp_host (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
      .lnk(lnk.host), .pin_levels(pin_levels), .take_control(take_control),
      .req(req), .cmd(cmd), .wdata(wdata), .busy(busy), .done(done),
      .rdata(rdata), .power_good_s(power_good_s));
   pmudcp_chk u_pmudcp_chk (.sys_clk(sys_clk), .rst(rst),
      .dynamic_mode(dynamic_mode), .ctrl_pin_one(lnk.ctrl_pin_one),
      .ctrl_pin_two_o(lnk.ctrl_pin_two_o),
      .ctrl_pin_two_oe(lnk.ctrl_pin_two_oe),
      .ctrl_pin_three(lnk.ctrl_pin_three), .ctrl_pin_four(lnk.ctrl_pin_four),
      .ready_irq_pin(lnk.ready_irq_pin), .power_good(lnk.power_good));

   always #2 sys_clk = ~sys_clk;

   // ****************************************
   // helpers
   // ****************************************
   task automatic finish_test();
      if (n_mismatch == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // counts pulses so a one-cycle strobe is never missed
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (done === 1'b1) n_done <= n_done + 1;
      if (reg_wr === 1'b1) n_wr <= n_wr + 1;
      if (reg_rd === 1'b1) n_rd <= n_rd + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         finish_test();
      end
   end

   task automatic reset_dut(input logic dyn, input logic [3:0] pins);
      @(negedge sys_clk);
      rst = 1'b1;
      {dynamic_mode, pin_levels} = {dyn, pins};
      {button_event, startup_done, take_control, req} = 4'h0;
      repeat (16) @(negedge sys_clk);
      chk({3'h0, lnk.power_good, supply_en}, 8'h00);
      rst = 1'b0;
      repeat (20) @(negedge sys_clk);
   endtask

   task automatic xfer(input logic [7:0] c, input logic [7:0] d,
                       input logic on);
      int k;
      int d0;
      int w0;
      int r0;
      // let select stand high long enough for the device to see it
      repeat (8) @(negedge sys_clk);
      {d0, w0, r0} = {n_done, n_wr, n_rd};
      {cmd, wdata, reg_rdata, req} = {c, d, d, 1'b1};
      @(negedge sys_clk);
      req = 1'b0;
      for (k = 0; k < 3000 && n_done == d0; k++) @(negedge sys_clk);
      chk({7'h0, n_done != d0}, 8'h01);
      chk({2'(n_wr - w0), 2'(n_rd - r0)}, {3'h0, on & !c[7], 1'b0, on & c[7]});
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      int k;
      {seq_enables, cmd, wdata, reg_rdata} = {4'hf, 24'h000000};
      reset_dut(1'b1, 4'hf);
      startup_done = 1'b1;
      chk({7'h0, select_pullup_en}, 8'h00);
      button_event = 1'b1;
      for (k = 0; k < 100 && select_pullup_en !== 1'b1; k++) @(negedge sys_clk);
      for (k = 0; k < 1000 && select_pullup_en === 1'b1; k++) @(negedge sys_clk);
      chk({7'h0, k >= 249 && k <= 260}, 8'h01);
      chk({6'h0, spi_selected, select_pullup_en}, 8'h02);
      button_event = 1'b0;
      foreach (rows[i]) begin
         xfer(rows[i].cmd, rows[i].data, 1'b1);
         if (rows[i].cmd[7])
            chk(rdata, rows[i].data);
         else
            chk(reg_wdata, rows[i].data);
         chk({1'b0, reg_addr}, {1'b0, rows[i].cmd[6:0]});
      end
      chk({7'h0, spi_selected}, 8'h01);
      // select held low at sampling: serial traffic must be ignored
      reset_dut(1'b1, 4'h7);
      {startup_done, button_event} = 2'b11;
      repeat (400) @(negedge sys_clk);
      chk({7'h0, spi_selected}, 8'h00);
      xfer(8'h05, 8'h77, 1'b0);
      chk({7'h0, spi_selected}, 8'h00);
      reset_dut(1'b0, 4'hf);
      chk({3'h0, lnk.power_good, supply_en}, 8'h07);
      startup_done = 1'b1;
      repeat (40) @(negedge sys_clk);
      chk({2'h0, ready_pullup_en, lnk.power_good, supply_en}, 8'h37);
      pin_levels = 4'b0101;
      repeat (20) @(negedge sys_clk);
      take_control = 1'b1;
      repeat (20) @(negedge sys_clk);
      chk({3'h0, ready_pullup_en, supply_en}, 8'h05);
      pin_levels = 4'b1010;
      repeat (20) @(negedge sys_clk);
      chk({4'h0, supply_en}, 8'h0a);
      finish_test();
   end
endmodule
